// ---- logic/spi_ctrl_regs.sv ----
// Configuration, event flag, select and serial clock logic of the high-speed serial controller
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps

module spi_ctrl_regs (
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // Events from the shift engine and buffers
   input  wire logic        i_transfer_done,
   input  wire logic        i_rx_buffers_full,
   input  wire logic        i_byte_received,
   input  wire logic        i_shift_active,
   input  wire logic        i_global_irq_enable,
   // Serial clock pin
   input  wire logic        i_serial_clock_pin,
   output logic             o_serial_clock_pin,
   output logic             o_serial_clock_pin_oe,
   // Slave select pin
   input  wire logic        i_slave_select_pin,
   output logic             o_slave_select_pin,
   output logic             o_slave_select_pin_oe,
   // Controller state
   output logic             o_controller_enable,
   output logic             o_master_role,
   output logic             o_clock_phase,
   output logic             o_clock_polarity,
   output logic             o_selected,
   output logic             o_sample_pulse,
   output logic             o_setup_pulse,
   output logic             o_serial_tick,
   // Buffer memory control
   output logic             o_buffer_enable,
   output logic             o_buffer_reset,
   // Interrupt
   output logic             o_serial_irq
);
   import spi_ctrl_pkg::*;

   // ****************************************************************
   // Divider decode
   // ****************************************************************
   function automatic logic [6:0] divisor_of(input logic [2:0] code);
      case (code)
         3'h0:    divisor_of = DIV_0;
         3'h1:    divisor_of = DIV_1;
         3'h2:    divisor_of = DIV_2;
         3'h3:    divisor_of = DIV_3;
         3'h4:    divisor_of = DIV_4;
         3'h5:    divisor_of = DIV_5;
         3'h6:    divisor_of = DIV_6;
         default: divisor_of = DIV_7;
      endcase
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0]  cfg_q;
   logic [7:0]  mask_q;
   logic [7:0]  events_q;
   logic [7:0]  events_d;
   logic [7:0]  ctrl_q;
   logic [15:0] timeout_q;
   logic [2:0]  active_code_q;
   logic        en_prev_q;
   logic        buf_prev_q;
   logic [1:0]  buf_rst_cnt_q;
   logic [6:0]  div_cnt_q;
   logic [6:0]  divisor;
   logic        tick_lead;
   logic        tick_trail;
   logic        sck_q;
   logic [1:0]  sck_sync_q;
   logic        sck_prev_q;
   logic [1:0]  ss_sync_q;
   logic        sel_prev_q;
   logic        sample_q;
   logic        setup_q;
   logic        tick_q;
   logic [15:0] tmr_cnt_q;
   tmr_state_e  tmr_q;
   logic        timeout_ev;
   logic [7:0]  rdata_q;

   logic        wr_cfg;
   logic        wr_mask;
   logic        wr_events;
   logic        wr_ctrl;
   logic        wr_to_lo;
   logic        wr_to_hi;
   logic        en;
   logic        en_toggle;
   logic        eff_pin;
   logic        selected;
   logic        sel_rise;
   logic        sel_fall;
   logic        lead_edge;
   logic        trail_edge;

   assign wr_cfg    = i_wr && (i_addr == OFS_CONFIG);
   assign wr_mask   = i_wr && (i_addr == OFS_IRQ_MASK);
   assign wr_events = i_wr && (i_addr == OFS_EVENTS);
   assign wr_ctrl   = i_wr && (i_addr == OFS_CONTROL);
   assign wr_to_lo  = i_wr && (i_addr == OFS_TIMEOUT_LO);
   assign wr_to_hi  = i_wr && (i_addr == OFS_TIMEOUT_HI);
   assign en        = cfg_q[CFG_ENABLE];
   assign en_toggle = en != en_prev_q;

   // ****************************************************************
   // Configuration register
   // ****************************************************************
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg_q <= RST_CONFIG;
      end else if (wr_cfg) begin
         cfg_q <= i_wdata;                                   // RULE10
         if (!i_wdata[CFG_ENABLE]) begin
            cfg_q[CFG_MASTER] <= 1'b0;                       // RULE8
         end
      end
   end

   // Divider code only follows the register while the controller is stopped
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         active_code_q <= RST_CONFIG[CFG_DIV_LSB +: 3];
      end else if (wr_cfg && !en) begin
         active_code_q <= i_wdata[CFG_DIV_LSB +: 3];         // RULE2 RULE10
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         en_prev_q  <= 1'b0;
         buf_prev_q <= 1'b0;
      end else begin
         en_prev_q  <= en;
         buf_prev_q <= cfg_q[CFG_BUF_MODE];
      end
   end

   // ****************************************************************
   // Mask, control and timeout value registers
   // ****************************************************************
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         mask_q <= RST_IRQ_MASK;
      end else if (wr_mask) begin
         mask_q <= i_wdata & IE_WRITABLE;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_q <= RST_CONTROL;
      end else if (wr_ctrl) begin
         ctrl_q <= i_wdata & CR_STORED;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         timeout_q <= {RST_TIMEOUT, RST_TIMEOUT};
      end else if (wr_to_lo) begin
         timeout_q[7:0] <= i_wdata;
      end else if (wr_to_hi) begin
         timeout_q[15:8] <= i_wdata;
      end
   end

   // ****************************************************************
   // Buffer memory enable and reset
   // ****************************************************************
   assign o_buffer_enable = cfg_q[CFG_BUF_MODE];             // RULE3

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         buf_rst_cnt_q <= 2'h0;
      end else if (buf_prev_q && !cfg_q[CFG_BUF_MODE]) begin
         buf_rst_cnt_q <= 2'(BUF_RESET_CYCLES);              // RULE4
      end else if (buf_rst_cnt_q != 2'h0) begin
         buf_rst_cnt_q <= buf_rst_cnt_q - 2'h1;
      end
   end

   assign o_buffer_reset = buf_rst_cnt_q != 2'h0;            // RULE4

   // ****************************************************************
   // Serial clock divider and master clock generation
   // ****************************************************************
   assign divisor    = divisor_of(active_code_q);            // RULE1
   assign tick_lead  = en && (div_cnt_q == 7'h00);
   assign tick_trail = en && (div_cnt_q == (divisor >> 1));

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         div_cnt_q <= 7'h00;
      end else if (!en || div_cnt_q >= divisor - 7'h01) begin
         div_cnt_q <= 7'h00;                                 // RULE9
      end else begin
         div_cnt_q <= div_cnt_q + 7'h01;                     // RULE1
      end
   end

   // Idle level is the polarity bit; leading edge leaves it, trailing edge returns
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         sck_q <= 1'b0;
      end else if (!(en && cfg_q[CFG_MASTER])) begin
         sck_q <= cfg_q[CFG_CPOL];                           // RULE7
      end else if (tick_lead && i_shift_active) begin
         sck_q <= !cfg_q[CFG_CPOL];                          // RULE7
      end else if (tick_trail) begin
         sck_q <= cfg_q[CFG_CPOL];                           // RULE7
      end
   end

   assign o_serial_clock_pin    = sck_q;
   assign o_serial_clock_pin_oe = en && cfg_q[CFG_MASTER];   // RULE8

   // ****************************************************************
   // Slave clock input and edge classification
   // ****************************************************************
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         sck_sync_q <= 2'h0;
         sck_prev_q <= 1'b0;
      end else begin
         sck_sync_q <= {sck_sync_q[0], i_serial_clock_pin};
         sck_prev_q <= sck_sync_q[1];
      end
   end

   always_comb begin
      lead_edge  = 1'b0;
      trail_edge = 1'b0;
      if (en && cfg_q[CFG_MASTER]) begin
         lead_edge  = tick_lead && i_shift_active && (sck_q == cfg_q[CFG_CPOL]);
         trail_edge = tick_trail && (sck_q != cfg_q[CFG_CPOL]);
      end else if (en && selected) begin
         lead_edge  = (sck_prev_q == cfg_q[CFG_CPOL]) && (sck_sync_q[1] != cfg_q[CFG_CPOL]);  // RULE7
         trail_edge = (sck_prev_q != cfg_q[CFG_CPOL]) && (sck_sync_q[1] == cfg_q[CFG_CPOL]);  // RULE7
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         sample_q <= 1'b0;
         setup_q  <= 1'b0;
         tick_q   <= 1'b0;
      end else begin
         sample_q <= cfg_q[CFG_CPHA] ? trail_edge : lead_edge;   // RULE6
         setup_q  <= cfg_q[CFG_CPHA] ? lead_edge : trail_edge;   // RULE6
         tick_q   <= tick_lead;
      end
   end

   assign o_sample_pulse = sample_q;
   assign o_setup_pulse  = setup_q;
   assign o_serial_tick  = tick_q;

   // ****************************************************************
   // Slave select handling
   // ****************************************************************
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ss_sync_q <= 2'h3;
      end else begin
         ss_sync_q <= {ss_sync_q[0], i_slave_select_pin};
      end
   end

   assign eff_pin  = ctrl_q[CR_SW_MODE] ? ctrl_q[CR_SW_VALUE] : ss_sync_q[1];   // RULE19
   assign selected = ctrl_q[CR_POLARITY] ? eff_pin : !eff_pin;                 // RULE18
   assign sel_rise = selected && !sel_prev_q;
   assign sel_fall = !selected && sel_prev_q;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         sel_prev_q <= 1'b0;
      end else begin
         sel_prev_q <= selected;
      end
   end

   assign o_selected            = selected;
   assign o_slave_select_pin    = ctrl_q[CR_CHIP_SEL];                         // RULE22
   assign o_slave_select_pin_oe = en && cfg_q[CFG_MASTER] && !ctrl_q[CR_SW_MODE];  // RULE22

   // ****************************************************************
   // Timeout timer
   // ****************************************************************
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tmr_q     <= TMR_IDLE;
         tmr_cnt_q <= 16'h0000;
      end else if (!(en && cfg_q[CFG_BUF_MODE])) begin
         tmr_q     <= TMR_IDLE;
         tmr_cnt_q <= 16'h0000;
      end else if (wr_ctrl && i_wdata[CR_START_TO]) begin
         tmr_q     <= TMR_ARMED;                                               // RULE20
         tmr_cnt_q <= 16'h0000;
      end else if (wr_ctrl && i_wdata[CR_REARM_TO] && tmr_q == TMR_RUN) begin
         tmr_cnt_q <= 16'h0000;
      end else begin
         case (tmr_q)
            TMR_ARMED: begin
               if (i_byte_received) begin
                  tmr_q <= TMR_RUN;                                            // RULE20
               end
            end
            TMR_RUN: begin
               if (tick_lead) begin
                  if (tmr_cnt_q + 16'h0001 >= timeout_q) begin
                     tmr_q <= TMR_IDLE;                                        // RULE21
                  end
                  tmr_cnt_q <= tmr_cnt_q + 16'h0001;                           // RULE21
               end
            end
            default: begin
               tmr_cnt_q <= 16'h0000;
            end
         endcase
      end
   end

   assign timeout_ev = en && cfg_q[CFG_BUF_MODE] && (tmr_q == TMR_RUN) && tick_lead
                       && (tmr_cnt_q + 16'h0001 >= timeout_q)
                       && !(wr_ctrl && (i_wdata[CR_START_TO] || i_wdata[CR_REARM_TO]));  // RULE21

   // ****************************************************************
   // Event flags
   // ****************************************************************
   always_comb begin
      events_d = events_q;
      if (wr_events) begin
         events_d = events_q & (i_wdata | ~EV_WRITABLE);                      // RULE23
      end
      if (en_toggle) begin
         events_d[EV_TIMEOUT] = 1'b0;                                          // RULE11
         events_d[EV_DONE]    = 1'b0;                                          // RULE12
      end
      if (!en) begin
         events_d[EV_DESELECT] = 1'b0;                                         // RULE14
         events_d[EV_SELECT]   = 1'b0;                                         // RULE15
      end
      // Hardware set wins over any clear in the same cycle
      if (timeout_ev) begin
         events_d[EV_TIMEOUT] = 1'b1;                                          // RULE11
      end
      if (en && i_transfer_done) begin
         events_d[EV_DONE] = 1'b1;                                             // RULE12
      end
      if (en && cfg_q[CFG_BUF_MODE] && i_rx_buffers_full) begin
         events_d[EV_OVERFLOW] = 1'b1;                                         // RULE13
      end
      if (en && sel_fall) begin
         events_d[EV_DESELECT] = 1'b1;                                         // RULE14
      end
      if (en && sel_rise) begin
         events_d[EV_SELECT] = 1'b1;                                           // RULE15
      end
      events_d = events_d & EV_WRITABLE;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         events_q <= RST_EVENTS;
      end else begin
         events_q <= events_d;
      end
   end

   // ****************************************************************
   // Interrupt request
   // ****************************************************************
   assign o_serial_irq = i_global_irq_enable && (                              // RULE24
                            (events_q[EV_TIMEOUT]  && mask_q[EV_TIMEOUT])  ||  // RULE16
                            (events_q[EV_DONE]     && mask_q[EV_DONE])     ||  // RULE16
                            (events_q[EV_OVERFLOW] && mask_q[EV_OVERFLOW]) ||  // RULE16
                            ((events_q[EV_DESELECT] || events_q[EV_SELECT]) && mask_q[IE_SELECT]));  // RULE17

   // ****************************************************************
   // Register read
   // ****************************************************************
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= 8'h00;
      end else if (!i_rd) begin
         rdata_q <= 8'h00;
      end else if (i_addr == OFS_CONFIG) begin
         rdata_q <= cfg_q;
      end else if (i_addr == OFS_IRQ_MASK) begin
         rdata_q <= mask_q;
      end else if (i_addr == OFS_EVENTS) begin
         rdata_q <= events_q;
      end else if (i_addr == OFS_CONTROL) begin
         rdata_q <= ctrl_q;
      end else if (i_addr == OFS_TIMEOUT_LO) begin
         rdata_q <= timeout_q[7:0];
      end else if (i_addr == OFS_TIMEOUT_HI) begin
         rdata_q <= timeout_q[15:8];
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign o_rdata             = rdata_q;
   assign o_controller_enable = en;                                            // RULE9
   assign o_master_role       = cfg_q[CFG_MASTER];                             // RULE8
   assign o_clock_phase       = cfg_q[CFG_CPHA];
   assign o_clock_polarity    = cfg_q[CFG_CPOL];

endmodule

// ---- logic/spi_ctrl_pkg.sv ----
// Constants shared by the high-speed serial controller register block
//
// Behaviour
// RULE1: Divider code picks divide by 4..96
// RULE2: Divider change ignored while controller enabled
// RULE3: Buffer-mode bit enables buffer and copy path
// RULE4: Disabling buffer mode resets buffer two cycles
// RULE5: Software leaves buffer alone during reset
// RULE6: Phase bit chooses sample or setup edge
// RULE7: Polarity bit sets idle level and edges
// RULE8: Role bit selects master; cleared with enable
// RULE9: Enable bit runs or stops the controller
// RULE10: One write configures and enables together
// RULE11: Timeout flag set; cleared by software, enable toggle
// RULE12: Done flag set; cleared by software, enable toggle
// RULE13: Overflow flag set when both receive buffers full
// RULE14: Deselect edge flag per polarity; cleared when disabled
// RULE15: Select edge flag per polarity; cleared when disabled
// RULE16: Timeout, done, overflow interrupt through enable bits
// RULE17: Select edges interrupt while select enable set
// RULE18: Polarity bit decides selected select-pin level
// RULE19: Select mode takes software value instead of pin
// RULE20: Start-timeout write arms timer until first byte
// RULE21: Timeout after programmed serial clock periods
// RULE22: Chip-select bit drives select pin level
// RULE23: Writing zero clears flag, one keeps it
// RULE24: Enabled flags merge into one held request
package spi_ctrl_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] OFS_TIMEOUT_LO     = 8'hd1;
   localparam logic [7:0] OFS_TIMEOUT_HI     = 8'hd2;
   localparam logic [7:0] OFS_IRQ_MASK       = 8'hd4;
   localparam logic [7:0] OFS_CONFIG         = 8'hd9;
   localparam logic [7:0] OFS_EVENTS         = 8'hda;
   localparam logic [7:0] OFS_CONTROL        = 8'hdb;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] RST_IRQ_MASK       = 8'h00;
   localparam logic [7:0] RST_CONFIG         = 8'h80;
   localparam logic [7:0] RST_EVENTS         = 8'h00;
   localparam logic [7:0] RST_CONTROL        = 8'h01;
   localparam logic [7:0] RST_TIMEOUT        = 8'h00;

   // ****************************************************************
   // Configuration fields
   // ****************************************************************
   localparam int CFG_DIV_LSB    = 5;
   localparam int CFG_BUF_MODE   = 4;
   localparam int CFG_CPHA       = 3;
   localparam int CFG_CPOL       = 2;
   localparam int CFG_MASTER     = 1;
   localparam int CFG_ENABLE     = 0;

   // ****************************************************************
   // Event flag and mask fields
   // ****************************************************************
   localparam int EV_TIMEOUT     = 7;
   localparam int EV_DONE        = 6;
   localparam int EV_OVERFLOW    = 5;
   localparam int EV_DESELECT    = 4;
   localparam int EV_SELECT      = 3;
   localparam int IE_SELECT      = 4;
   localparam logic [7:0] EV_WRITABLE  = 8'hf8;
   localparam logic [7:0] IE_WRITABLE  = 8'hf0;

   // ****************************************************************
   // Control fields
   // ****************************************************************
   localparam int CR_POLARITY    = 5;
   localparam int CR_SW_VALUE    = 4;
   localparam int CR_SW_MODE     = 3;
   localparam int CR_START_TO    = 2;
   localparam int CR_REARM_TO    = 1;
   localparam int CR_CHIP_SEL    = 0;
   localparam logic [7:0] CR_STORED    = 8'h39;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int BUF_RESET_CYCLES = 2;
   localparam logic [6:0] DIV_0 = 7'h04;
   localparam logic [6:0] DIV_1 = 7'h05;
   localparam logic [6:0] DIV_2 = 7'h06;
   localparam logic [6:0] DIV_3 = 7'h08;
   localparam logic [6:0] DIV_4 = 7'h0c;
   localparam logic [6:0] DIV_5 = 7'h18;
   localparam logic [6:0] DIV_6 = 7'h30;
   localparam logic [6:0] DIV_7 = 7'h60;

   typedef enum logic [1:0] {
      TMR_IDLE  = 2'b00,
      TMR_ARMED = 2'b01,
      TMR_RUN   = 2'b10
   } tmr_state_e;

endpackage

// ---- verif/spi_ctrl_regs_checker.sv ----
// Port assertions of the serial controller register block
`timescale 1ns/100ps

module spi_ctrl_regs_checker (
   // Clock, reset and bus
   input wire logic       i_sys_clk,
   input wire logic       i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_global_irq_enable,
   // Watched outputs
   input wire logic       o_serial_irq,
   input wire logic       o_serial_clock_pin_oe,
   input wire logic       o_serial_clock_pin,
   input wire logic       o_slave_select_pin,
   input wire logic       o_controller_enable,
   input wire logic       o_master_role,
   input wire logic       o_clock_polarity,
   input wire logic       o_buffer_enable,
   input wire logic       o_buffer_reset
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   sequence cfg_wr;
      i_wr && i_addr == 8'hd9;
   endsequence
   sequence buf_rst_2;
      (!o_buffer_enable && o_buffer_reset) ##1 o_buffer_reset ##1 !o_buffer_reset;
   endsequence
   chk_clock_oe_role: assert property (o_serial_clock_pin_oe == (o_controller_enable && o_master_role))
      else $error("clock pin driven outside master role");
   chk_role_needs_enable: assert property (!o_controller_enable |-> !o_master_role)
      else $error("master role kept while disabled");
   chk_cfg_applied: assert property (cfg_wr |=> o_controller_enable == $past(i_wdata[0]) && o_clock_polarity == $past(i_wdata[2]))
      else $error("configuration write not applied");
   chk_buffer_follows: assert property (cfg_wr |=> o_buffer_enable == $past(i_wdata[4]))
      else $error("buffer enable does not follow its bit");
   chk_buffer_reset_len: assert property ($rose(o_buffer_reset) |-> buf_rst_2)
      else $error("buffer reset not two cycles");
   chk_buffer_reset_cause: assert property ($fell(o_buffer_enable) |-> ##[0:2] $rose(o_buffer_reset))
      else $error("buffer reset missing after disable");
   chk_irq_gated: assert property (!i_global_irq_enable |-> !o_serial_irq)
      else $error("interrupt without global enable");
   chk_select_drive: assert property (i_wr && i_addr == 8'hdb |=> o_slave_select_pin == $past(i_wdata[0]))
      else $error("select pin differs from control bit");
   chk_clock_idle_level: assert property (!o_serial_clock_pin_oe |=> o_serial_clock_pin == $past(o_clock_polarity))
      else $error("serial clock not at idle level");
endmodule

bind spi_ctrl_regs spi_ctrl_regs_checker spi_ctrl_regs_checker_inst (
   .i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_global_irq_enable, .o_serial_irq,
   .o_serial_clock_pin_oe, .o_serial_clock_pin, .o_slave_select_pin, .o_controller_enable, .o_master_role,
   .o_clock_polarity, .o_buffer_enable, .o_buffer_reset);

// ---- verif/spi_far_master.sv ----
// Far-side serial master driving the select and clock pins
`timescale 1ns/100ps

module spi_far_master (
   // Clock and request
   input  wire logic i_sys_clk,
   input  wire logic i_select,
   // Pins
   output logic      o_select_pin_n = 1'b1,
   output logic      o_clock_pin = 1'b0
);
   logic [1:0] div_q = 2'h0;
   always @(posedge i_sys_clk) begin
      o_select_pin_n <= !i_select;
      div_q          <= i_select ? div_q + 2'h1 : 2'h0;
      o_clock_pin    <= i_select && div_q[1];
   end
endmodule

// ---- verif/tb_spi_ctrl_regs.sv ----
// Self-checking bench for the serial controller register block
`timescale 1ns/100ps

module tb_spi_ctrl_regs;
   logic       i_sys_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, sel = 1'b0, rx = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
   logic       i_transfer_done = 1'b0, i_rx_buffers_full = 1'b0, i_global_irq_enable = 1'b0;
   logic       i_serial_clock_pin, i_slave_select_pin, o_serial_tick, o_serial_irq, o_buffer_enable;
   int         fails = 0, total_checks = 0, n, k;
   int         dv[8] = '{4, 5, 6, 8, 12, 24, 48, 96};

   spi_ctrl_regs spi_ctrl_regs_inst (
      .i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_transfer_done,
      .i_rx_buffers_full, .i_byte_received(rx), .i_shift_active(1'b1), .i_global_irq_enable,
      .i_serial_clock_pin, .o_serial_clock_pin(), .o_serial_clock_pin_oe(), .i_slave_select_pin,
      .o_slave_select_pin(), .o_slave_select_pin_oe(), .o_controller_enable(), .o_master_role(),
      .o_clock_phase(), .o_clock_polarity(), .o_selected(), .o_sample_pulse(), .o_setup_pulse(),
      .o_serial_tick, .o_buffer_enable, .o_buffer_reset(), .o_serial_irq);
   spi_far_master spi_far_master_inst (
      .i_sys_clk, .i_select(sel), .o_select_pin_n(i_slave_select_pin), .o_clock_pin(i_serial_clock_pin));

   initial forever #12.5 i_sys_clk = ~i_sys_clk;

   task automatic chk(input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge i_sys_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr    <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, e);
      @(posedge i_sys_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd   <= 1'b0;
      #1;
      chk(o_rdata, e);
   endtask
   task automatic pulse;
      @(posedge i_sys_clk);
      i_transfer_done   <= 1'b1;
      i_rx_buffers_full <= 1'b1;
      @(posedge i_sys_clk);
      i_transfer_done   <= 1'b0;
      i_rx_buffers_full <= 1'b0;
      cyc(2);
   endtask
   // Cycles between two serial ticks, into n
   task automatic gap;
      for (k = 0; k < 200 && o_serial_tick !== 1'b1; k++) cyc(1);
      for (n = 1; n < 200; n++) begin
         cyc(1);
         if (o_serial_tick === 1'b1) break;
      end
      if (k == 200 || n == 200) begin
         fails++;
         end_of_test;
      end
   endtask

   task automatic t_reset;
      rdc(8'hd4, 8'h00);
      rdc(8'hd9, 8'h80);
      rdc(8'hda, 8'h00);
      rdc(8'hdb, 8'h01);
      rdc(8'hd3, 8'h00);
   endtask
   task automatic t_divider;
      for (int c = 0; c < 8; c++) begin
         wr(8'hd9, 8'(c << 5) | 8'h01);
         gap();
         chk(8'(n), 8'(dv[c]));
         wr(8'hd9, 8'h00);
      end
      wr(8'hd9, 8'h01);
      wr(8'hd9, 8'he1);
      gap();
      chk(8'(n), 8'h04);
      wr(8'hd9, 8'h03);
      wr(8'hd9, 8'h02);
      rdc(8'hd9, 8'h00);
   endtask
   task automatic t_flags;
      wr(8'hd9, 8'h11);
      wr(8'hd1, 8'h03);
      wr(8'hdb, 8'h04);
      rx <= 1'b1;
      cyc(1);
      rx <= 1'b0;
      cyc(4);
      rdc(8'hda, 8'h00);
      cyc(12);
      rdc(8'hda, 8'h80);
      wr(8'hda, 8'h00);
      wr(8'hd4, 8'h60);
      i_global_irq_enable <= 1'b1;
      pulse();
      chk(8'(o_serial_irq), 8'h01);
      rdc(8'hda, 8'h60);
      wr(8'hda, 8'hbf);
      rdc(8'hda, 8'h20);
      wr(8'hd4, 8'h00);
      cyc(1);
      chk(8'(o_serial_irq), 8'h00);
      pulse();
      wr(8'hd9, 8'h10);
      rdc(8'hda, 8'h20);
      wr(8'hd9, 8'h00);
      chk(8'(o_buffer_enable), 8'h00);
      cyc(2);
   endtask
   task automatic t_select;
      wr(8'hd9, 8'h01);
      wr(8'hda, 8'h00);
      wr(8'hd4, 8'h10);
      sel <= 1'b1;
      cyc(6);
      chk(8'(o_serial_irq), 8'h01);
      rdc(8'hda, 8'h08);
      @(posedge i_sys_clk);
      sel <= 1'b0;
      cyc(6);
      rdc(8'hda, 8'h18);
      wr(8'hda, 8'h00);
      wr(8'hdb, 8'h09);
      cyc(3);
      rdc(8'hda, 8'h08);
      wr(8'hd9, 8'h00);
      rdc(8'hda, 8'h00);
   endtask

   initial begin
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      t_reset();
      t_divider();
      t_flags();
      t_select();
      end_of_test();
   end
endmodule
